// [rtl/dse_pkg.sv]
// constants, types and register layout for the exception entry block
//
// Function
// [RULE_01] system call stores next instruction address in save_restore_pc
// [RULE_02] state goes to save_restore_state before the system call is taken
// [RULE_03] saved state copies 0,48-55,57-59,62-63; clears 33-36, 42-47
// [RULE_04] further machine state bits may also be copied on entry
// [RULE_05] entry sets 64-bit mode, clears listed bits, endian from exception
// [RULE_06] exception 64-bit mode bit is copied into 64-bit mode on any entry; code always sets 64-bit mode to 1 instead
// [RULE_07] decrementer entry fetches at base plus 0x00900
// [RULE_08] system call entry fetches at base plus 0x00c00, new prefix bit
// [RULE_09] system call entry is context synchronizing; prior effects finish
// [RULE_10] decrementer msb rise sets one collapsed request; taking clears it
// [RULE_11] decrementer entry saves next fetch address in save_restore_pc
// [RULE_12] decrementer taken only with irqs enabled, nothing higher pending
package dse_pkg;
   // machine state bit numbers, big-endian 64-bit numbering (0 = msb)
   localparam int BIT_SIXTY_FOUR     = 0;
   localparam int BIT_EXC_SIXTY_FOUR = 2;
   localparam int BIT_POWER_SAVE     = 45;
   localparam int BIT_EXC_LITTLE_END = 47;
   localparam int BIT_EXT_IRQ_EN     = 48;
   localparam int BIT_PROBLEM        = 49;
   localparam int BIT_FP_AVAIL       = 50;
   localparam int BIT_MCHK_EN        = 51;
   localparam int BIT_FP_MODE_LO     = 52;
   localparam int BIT_STEP_TRACE     = 53;
   localparam int BIT_BRANCH_TRACE   = 54;
   localparam int BIT_FP_MODE_HI     = 55;
   localparam int BIT_PREFIX         = 57;
   localparam int BIT_INSN_RELOC     = 58;
   localparam int BIT_DATA_RELOC     = 59;
   localparam int BIT_RECOVERABLE    = 62;
   localparam int BIT_LITTLE_END     = 63;

   // save mask: bits copied into the state save register
   localparam logic [63:0] SAVE_MASK = 64'h8000_0000_0000_ff73;
   localparam logic [63:0] MST_RESET = 64'h0000_0000_0000_0000;

   localparam logic [19:0] VEC_DEC      = 20'h00900;
   localparam logic [19:0] VEC_SYSCALL  = 20'h00c00;
   localparam logic [63:0] BASE_PREFIX1 = 64'h0000_0000_fff0_0000;
   localparam logic [63:0] BASE_PREFIX0 = 64'h0000_0000_0000_0000;

   // avalon register word addresses
   localparam logic [3:0] ADR_MST_LO  = 4'h0;
   localparam logic [3:0] ADR_MST_HI  = 4'h1;
   localparam logic [3:0] ADR_PC_LO   = 4'h2;
   localparam logic [3:0] ADR_PC_HI   = 4'h3;
   localparam logic [3:0] ADR_ST_LO   = 4'h4;
   localparam logic [3:0] ADR_ST_HI   = 4'h5;
   localparam logic [3:0] ADR_IRQ_ST  = 4'h6;
   localparam logic [3:0] ADR_IRQ_MSK = 4'h7;
   localparam logic [3:0] ADR_CTRL    = 4'h8;
   localparam logic [31:0] UNMAPPED   = 32'hdead_0000;

   // interrupt status bits
   localparam int IRQ_DEC = 0;
   localparam int IRQ_SC  = 1;

   typedef enum logic [1:0] {EXC_NONE, EXC_DEC, EXC_SC} dse_exc_e;

   typedef struct packed {
      logic        valid;
      logic [63:0] next_pc;
   } dse_sc_s;

   typedef struct packed {
      logic        valid;
      logic [63:0] vector;
   } dse_redir_s;

   // bit position in lsb-0 vector for a big-endian bit number
   function automatic int bp(input int n);
      return 63 - n;
   endfunction : bp
endpackage : dse_pkg

// [rtl/dse_entry_calc.sv]
// next machine state, saved state and vector for an exception entry
`timescale 1ns/1ps
module dse_entry_calc (
   // current state
   input  wire logic [63:0]       cur_state,
   input  wire dse_pkg::dse_exc_e kind,
   // results
   output logic [63:0]            next_state,
   output logic [63:0]            saved,
   output logic [63:0]            vector
);
   always_comb begin
      saved = cur_state & dse_pkg::SAVE_MASK; // RULE_03 RULE_04
      next_state = cur_state;
      next_state[dse_pkg::bp(dse_pkg::BIT_SIXTY_FOUR)] = 1'b1; // RULE_05
      // 64-bit mode is forced to 1; ORing in the exception copy bit changes nothing
      next_state[dse_pkg::bp(dse_pkg::BIT_SIXTY_FOUR)] =
         cur_state[dse_pkg::bp(dse_pkg::BIT_EXC_SIXTY_FOUR)] | 1'b1; // RULE_06
      next_state[dse_pkg::bp(dse_pkg::BIT_POWER_SAVE)]   = 1'b0; // RULE_05
      next_state[dse_pkg::bp(dse_pkg::BIT_EXT_IRQ_EN)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_PROBLEM)]      = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_FP_AVAIL)]     = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_FP_MODE_LO)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_STEP_TRACE)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_BRANCH_TRACE)] = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_FP_MODE_HI)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_INSN_RELOC)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_DATA_RELOC)]   = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_RECOVERABLE)]  = 1'b0;
      next_state[dse_pkg::bp(dse_pkg::BIT_LITTLE_END)]   =
         cur_state[dse_pkg::bp(dse_pkg::BIT_EXC_LITTLE_END)]; // RULE_05
      // prefix is unchanged, so "new" prefix equals the old one
      vector = cur_state[dse_pkg::bp(dse_pkg::BIT_PREFIX)] ?
               dse_pkg::BASE_PREFIX1 : dse_pkg::BASE_PREFIX0;
      if (kind == dse_pkg::EXC_SC) begin
         vector[19:0] = dse_pkg::VEC_SYSCALL; // RULE_08
      end else begin
         vector[19:0] = dse_pkg::VEC_DEC; // RULE_07
      end
   end
endmodule : dse_entry_calc

// [rtl/dse_exc_entry.sv]
// decrementer and system call exception entry with avalon register access
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module dse_exc_entry (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // instruction sequencer
   input  wire logic        sc_valid,
   input  wire logic [63:0] sc_next_pc,
   input  wire logic [63:0] seq_next_pc,
   input  wire logic        seq_quiet,
   input  wire logic        higher_pending,
   // decrement timer
   input  wire logic        dec_msb,
   // fetch redirect and status
   output logic             redirect_valid,
   output logic [63:0]      redirect_pc,
   output logic             sync_busy,
   output logic             irq
);
   logic [63:0] machine_state_reg_q;
   logic [63:0] save_restore_pc_q;
   logic [63:0] save_restore_state_q;
   logic        dec_msb_q;
   logic        dec_pend_q;
   logic [1:0]  irq_st_q;
   logic [1:0]  irq_msk_q;
   logic        sc_hold_q;
   logic [63:0] sc_pc_q;
   logic        dec_enable_q;
   logic [63:0] state_new;
   logic [63:0] saved;
   logic [63:0] vector;
   logic        take_sc;
   logic        take_dec;
   logic        st_rd;
   logic [31:0] rd_d;
   dse_pkg::dse_exc_e kind;

   // dec_msb is produced by the timer in this clock domain
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dec_msb_q <= 1'b0;
      end else begin
         dec_msb_q <= dec_msb;
      end
   end

   // system call waits until earlier context changes drain
   assign take_sc  = (sc_valid | sc_hold_q) & seq_quiet; // RULE_09
   assign take_dec = dec_pend_q & ~take_sc & ~higher_pending &
                     machine_state_reg_q[dse_pkg::bp(dse_pkg::BIT_EXT_IRQ_EN)] &
                     dec_enable_q; // RULE_12
   assign kind = take_sc ? dse_pkg::EXC_SC :
                 (take_dec ? dse_pkg::EXC_DEC : dse_pkg::EXC_NONE);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sc_hold_q <= 1'b0;
         sc_pc_q   <= '0;
      end else if (take_sc) begin
         sc_hold_q <= 1'b0;
      end else if (sc_valid) begin
         sc_hold_q <= 1'b1;
         sc_pc_q   <= sc_next_pc;
      end
   end

   // rising msb sets the request; many rises collapse; a new rise wins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dec_pend_q <= 1'b0;
      end else if (dec_msb & ~dec_msb_q) begin
         dec_pend_q <= 1'b1; // RULE_10
      end else if (take_dec) begin
         dec_pend_q <= 1'b0; // RULE_10
      end
   end

   dse_entry_calc u_calc (
      .cur_state  (machine_state_reg_q),
      .kind       (kind),
      .next_state (state_new),
      .saved      (saved),
      .vector     (vector)
   );

   // state saved from the old value in the same edge that enters
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         save_restore_pc_q    <= '0;
         save_restore_state_q <= '0;
      end else if (take_sc) begin
         save_restore_pc_q    <= sc_valid & ~sc_hold_q ?
                                 sc_next_pc : sc_pc_q; // RULE_01
         save_restore_state_q <= saved; // RULE_02 RULE_03
      end else if (take_dec) begin
         save_restore_pc_q    <= seq_next_pc; // RULE_11
         save_restore_state_q <= saved; // RULE_03
      end else if (avs_write & ~avs_waitrequest) begin
         if (avs_address == dse_pkg::ADR_PC_LO) begin
            save_restore_pc_q[31:0] <= avs_writedata;
         end else if (avs_address == dse_pkg::ADR_PC_HI) begin
            save_restore_pc_q[63:32] <= avs_writedata;
         end else if (avs_address == dse_pkg::ADR_ST_LO) begin
            save_restore_state_q[31:0] <= avs_writedata;
         end else if (avs_address == dse_pkg::ADR_ST_HI) begin
            save_restore_state_q[63:32] <= avs_writedata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         machine_state_reg_q <= dse_pkg::MST_RESET;
      end else if (take_sc | take_dec) begin
         machine_state_reg_q <= state_new; // RULE_05 RULE_06
      end else if (avs_write & ~avs_waitrequest) begin
         if (avs_address == dse_pkg::ADR_MST_LO) begin
            machine_state_reg_q[31:0] <= avs_writedata;
         end else if (avs_address == dse_pkg::ADR_MST_HI) begin
            machine_state_reg_q[63:32] <= avs_writedata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         redirect_valid <= 1'b0;
         redirect_pc    <= '0;
         sync_busy      <= 1'b0;
      end else begin
         redirect_valid <= take_sc | take_dec; // RULE_07 RULE_08
         redirect_pc    <= vector;
         sync_busy      <= (sc_valid | sc_hold_q) & ~take_sc; // RULE_09
      end
   end

   // control and mask
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_msk_q    <= '0;
         dec_enable_q <= 1'b1;
      end else if (avs_write & ~avs_waitrequest) begin
         if (avs_address == dse_pkg::ADR_IRQ_MSK) begin
            irq_msk_q <= avs_writedata[1:0];
         end else if (avs_address == dse_pkg::ADR_CTRL) begin
            dec_enable_q <= avs_writedata[0];
         end
      end
   end

   // sticky status; set wins over the read clear
   assign st_rd = avs_read & ~avs_waitrequest &
                  (avs_address == dse_pkg::ADR_IRQ_ST);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_st_q <= '0;
      end else begin
         irq_st_q[dse_pkg::IRQ_DEC] <= take_dec |
            (irq_st_q[dse_pkg::IRQ_DEC] & ~st_rd);
         irq_st_q[dse_pkg::IRQ_SC] <= take_sc |
            (irq_st_q[dse_pkg::IRQ_SC] & ~st_rd);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st_q & irq_msk_q);
      end
   end

   // one wait cycle: data registered, then accepted
   always_comb begin
      rd_d = dse_pkg::UNMAPPED;
      if (avs_address == dse_pkg::ADR_MST_LO) begin
         rd_d = machine_state_reg_q[31:0];
      end else if (avs_address == dse_pkg::ADR_MST_HI) begin
         rd_d = machine_state_reg_q[63:32];
      end else if (avs_address == dse_pkg::ADR_PC_LO) begin
         rd_d = save_restore_pc_q[31:0];
      end else if (avs_address == dse_pkg::ADR_PC_HI) begin
         rd_d = save_restore_pc_q[63:32];
      end else if (avs_address == dse_pkg::ADR_ST_LO) begin
         rd_d = save_restore_state_q[31:0];
      end else if (avs_address == dse_pkg::ADR_ST_HI) begin
         rd_d = save_restore_state_q[63:32];
      end else if (avs_address == dse_pkg::ADR_IRQ_ST) begin
         rd_d = {30'h0, irq_st_q};
      end else if (avs_address == dse_pkg::ADR_IRQ_MSK) begin
         rd_d = {30'h0, irq_msk_q};
      end else if (avs_address == dse_pkg::ADR_CTRL) begin
         rd_d = {31'h0, dec_enable_q};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            avs_readdata <= rd_d;
         end
      end
   end
endmodule : dse_exc_entry

// [test/dse_exc_entry_assertions.sv]
// concurrent checks on the exception entry block ports
`timescale 1ns/1ps
module dse_exc_chk (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // sequencer and fetch
   input wire logic        sc_valid,
   input wire logic        seq_quiet,
   input wire logic        higher_pending,
   input wire logic        redirect_valid,
   input wire logic [63:0] redirect_pc,
   input wire logic        sync_busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus request not answered");
   bus_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait request stayed low");
   unmapped_rd_a: assert property (avs_read && avs_waitrequest
      && avs_address > 4'h8 |=> avs_readdata == 32'hdead_0000)
      else $error("unmapped read data wrong");
   sc_entry_a: assert property (
      sc_valid && seq_quiet |=> redirect_valid
      && redirect_pc[19:0] == 20'h00c00) else $error("system call entry bad");
   sc_wait_a: assert property (
      (sc_valid || sync_busy) && !seq_quiet
      |=> sync_busy && !redirect_valid) else $error("entry before quiet");
   sc_resume_a: assert property (sync_busy && seq_quiet
      |=> !sync_busy && redirect_valid) else $error("held call not taken");
   dec_block_a: assert property (higher_pending && !sc_valid
      && !sync_busy |=> !redirect_valid) else $error("entry while blocked");
   dec_vector_a: assert property (
      redirect_valid && !$past(sc_valid)
      && !$past(sync_busy) |-> redirect_pc[19:0] == 20'h00900)
      else $error("decrementer vector wrong");
   vec_base_a: assert property (redirect_valid
      |-> redirect_pc[63:20] inside {44'h0, 44'hfff})
      else $error("vector base wrong");
endmodule : dse_exc_chk
bind dse_exc_entry dse_exc_chk u_chk (.*);

// [test/dse_seq_model.sv]
// sequencer and decrement timer model facing the entry block
`timescale 1ns/1ps
module dse_seq_model (
   // clock
   input wire logic    clk_sys,
   // to the entry block
   output logic        sc_valid,
   output logic [63:0] sc_next_pc,
   output logic [63:0] seq_next_pc,
   output logic        seq_quiet,
   output logic        higher_pending,
   output logic        dec_msb
);
   initial begin
      sc_valid = 1'b0;
      sc_next_pc = '0;
      seq_next_pc = '0;
      seq_quiet = 1'b1;
      higher_pending = 1'b0;
      dec_msb = 1'b0;
   end
   task automatic set(input logic q, input logic h, input logic [63:0] pc);
      @(posedge clk_sys);
      seq_quiet <= q;
      higher_pending <= h;
      seq_next_pc <= pc;
   endtask : set
   // address is scrambled once the pulse is over, so a stale hold shows
   task automatic syscall(input logic [63:0] pc);
      @(posedge clk_sys);
      sc_valid <= 1'b1;
      sc_next_pc <= pc;
      @(posedge clk_sys);
      sc_valid <= 1'b0;
      sc_next_pc <= ~pc;
   endtask : syscall
   task automatic dec_edge;
      @(posedge clk_sys);
      dec_msb <= 1'b0;
      @(posedge clk_sys);
      dec_msb <= 1'b1;
   endtask : dec_edge
endmodule : dse_seq_model

// [test/tb_dse_exc_entry.sv]
// self-checking bench for the exception entry block
`timescale 1ns/1ps
module tb_dse_exc_entry;
   logic        clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        sc_valid, seq_quiet, higher_pending, dec_msb;
   logic        redirect_valid, sync_busy, irq;
   logic [63:0] sc_next_pc, seq_next_pc, redirect_pc, last_pc;
   int          num_errors, checks, n_redir;

   dse_exc_entry uut (.clk_sys(clk_sys), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sc_valid(sc_valid),
      .sc_next_pc(sc_next_pc), .seq_next_pc(seq_next_pc),
      .seq_quiet(seq_quiet), .higher_pending(higher_pending),
      .dec_msb(dec_msb), .redirect_valid(redirect_valid),
      .redirect_pc(redirect_pc), .sync_busy(sync_busy), .irq(irq));
   dse_seq_model m (.clk_sys(clk_sys), .sc_valid(sc_valid),
      .sc_next_pc(sc_next_pc), .seq_next_pc(seq_next_pc),
      .seq_quiet(seq_quiet), .higher_pending(higher_pending),
      .dec_msb(dec_msb));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (redirect_valid === 1'b1) begin
      n_redir++;
      last_pc = redirect_pc;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // values read just after the edge are the ones the edge sampled
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wait_redir(input int n);
      for (int i = 0; i < 100 && n_redir < n; i++) @(posedge clk_sys);
   endtask : wait_redir

   task automatic t_syscall;
      bus(1, dse_pkg::ADR_IRQ_MSK, 32'h0);
      bus(1, dse_pkg::ADR_MST_LO, 32'hffff_ffff);
      bus(1, dse_pkg::ADR_MST_HI, 32'h7800_0000);
      m.syscall(64'h0000_0012_3456_7890);
      wait_redir(1);
      chk(last_pc, 64'hfff0_0c00);
      bus(0, dse_pkg::ADR_PC_LO, 32'h0);
      chk(q, 32'h3456_7890);
      bus(0, dse_pkg::ADR_PC_HI, 32'h0);
      chk(q, 32'h12);
      bus(0, dse_pkg::ADR_ST_LO, 32'h0);
      chk(q & 32'h003f_ff73, 32'h0000_ff73);
      bus(0, dse_pkg::ADR_ST_HI, 32'h0);
      chk(q & 32'hf800_0000, 32'h0);
      bus(0, dse_pkg::ADR_MST_LO, 32'h0);
      chk(q & 32'h0005_ff73, 32'h0001_1041);
      bus(0, dse_pkg::ADR_MST_HI, 32'h0);
      chk(q[31], 1'b1);
      chk(irq, 1'b0);
      bus(1, dse_pkg::ADR_IRQ_MSK, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b1);
      bus(0, dse_pkg::ADR_IRQ_ST, 32'h0);
      chk(q & 32'h3, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
   endtask : t_syscall

   task automatic t_sync;
      m.set(1'b0, 1'b0, 64'h0);
      m.syscall(64'h40);
      repeat (5) @(posedge clk_sys);
      chk(sync_busy, 1'b1);
      chk(n_redir, 1);
      m.set(1'b1, 1'b0, 64'h0);
      wait_redir(2);
      chk(last_pc, 64'hfff0_0c00);
      bus(0, dse_pkg::ADR_PC_LO, 32'h0);
      chk(q, 32'h40);
   endtask : t_sync

   task automatic t_dec;
      bus(1, dse_pkg::ADR_MST_LO, 32'h0000_8000);
      bus(1, dse_pkg::ADR_IRQ_MSK, 32'h1);
      m.set(1'b1, 1'b1, 64'h5a5c);
      m.dec_edge;
      m.dec_edge;
      repeat (5) @(posedge clk_sys);
      chk(n_redir, 2);
      m.set(1'b1, 1'b0, 64'h5a5c);
      wait_redir(3);
      repeat (10) @(posedge clk_sys);
      chk(n_redir, 3);
      chk(last_pc, 64'h900);
      bus(0, dse_pkg::ADR_PC_LO, 32'h0);
      chk(q, 32'h5a5c);
      bus(0, dse_pkg::ADR_ST_LO, 32'h0);
      chk(q & 32'h0000_8000, 32'h8000);
      chk(irq, 1'b1);
      bus(0, dse_pkg::ADR_IRQ_ST, 32'h0);
      chk(q[0], 1'b1);
      m.dec_edge;
      repeat (10) @(posedge clk_sys);
      chk(n_redir, 3);
   endtask : t_dec

   // request left pending by t_dec is held while the enable is off
   task automatic t_ctrl;
      bus(1, dse_pkg::ADR_CTRL, 32'h0);
      bus(1, dse_pkg::ADR_MST_LO, 32'h0000_8000);
      repeat (5) @(posedge clk_sys);
      chk(n_redir, 3);
      bus(0, dse_pkg::ADR_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1, dse_pkg::ADR_CTRL, 32'h1);
      wait_redir(4);
      chk(n_redir, 4);
      chk(last_pc, 64'h900);
   endtask : t_ctrl

   task automatic give_verdict;
      $display("num_errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   initial begin
      rst_b = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_syscall;
      t_sync;
      t_dec;
      t_ctrl;
      bus(0, 4'hf, 32'h0);
      chk(q, 32'hdead_0000);
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      give_verdict;
   end
endmodule : tb_dse_exc_entry
